// [rtl/adcsel_top.sv]
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Reference: 00 supply, 01 external pin, 1x amplifier output.
// - Internal reference wins over the external reference pin.
// - Amplifier input: external pin when select bit clear, bandgap when set.
// - Both amplifier inputs selected: bandgap only.
// - Converter-input pin function disables all other pin functions.
// - Pull-high removed while a pin is a converter input.
// - Converter-input function overrides the port direction control.
// - Classes 0000, 0100, 1100-1111 convert pin chosen by channel 0-11.
// - Channel 12-15 on external class leaves the input floating.
// - Classes 0001-0011 convert supply at 1, 1/2, 1/4.
// - Classes 0101-0111 convert amplifier output at 1, 1/2, 1/4.
// - Classes 1000-1011 are reserved and ground the input.
// - Internal signal wins; external path switched off.
// - Sampling lasts 4 converter clocks, conversion 12.
// - Conversion runs in hardware without software help.
// - Start bit low-high-low pulse begins a conversion.
// - Busy set at start, cleared at end, irq flag raised at end.
// - Converter clock is system clock over 2**divider, 000 to 111.
module adcsel_top
  import adcsel_pkg::*;
#(
  parameter int NPINS = 12
) (
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  input wire logic [NPINS-1:0] PORT_OE_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  output logic [1:0] REF_ROUTE_OUT,
  output logic AMP_BANDGAP_OUT,
  output logic [3:0] SRC_ROUTE_OUT,
  output logic [NPINS-1:0] CHAN_ENABLE_OUT,
  output logic [NPINS-1:0] PIN_ALT_EN_OUT,
  output logic [NPINS-1:0] PIN_PULL_EN_OUT,
  output logic [NPINS-1:0] PIN_OE_OUT,
  output logic SAMPLE_OUT,
  output logic CONVERT_OUT,
  output logic BUSY_OUT,
  output logic IRQ_FLAG_OUT
);
  import adcsel_pkg::*;

  // ****************************************
  // Bus slave state
  // ****************************************
  logic wr_pend, next_wr_pend;
  logic [7:0] wr_addr, next_wr_addr;
  logic [31:0] next_rdata;
  logic start_bit, next_start_bit;
  logic irq_flag, next_irq_flag;
  logic [3:0] channel_select, next_channel_select;
  logic [3:0] input_class_select, next_input_class_select;
  logic [2:0] converter_clock_divider, next_converter_clock_divider;
  logic [1:0] reference_source_select, next_reference_source_select;
  logic amp_input_select, next_amp_input_select;
  logic [NPINS-1:0] pin_function_select, next_pin_function_select;
  logic [NPINS-1:0] pull_request, next_pull_request;
  logic start_pulse, done_pulse;

  // ****************************************
  // Sequencer state
  // ****************************************
  adcsel_state_t state, next_state;
  logic [3:0] period_cnt, next_period_cnt;
  logic [1:0] ref_route, next_ref_route;
  logic amp_bg, next_amp_bg;
  logic [3:0] src_route, next_src_route;
  logic [NPINS-1:0] chan_en, next_chan_en;
  logic [3:0] live_src;
  logic [NPINS-1:0] live_chan;
  logic tick, busy;

  assign busy = (state != ADCSEL_IDLE);

  // Address phase capture and register writes
  always_comb begin
    next_wr_pend = 1'b0;
    next_wr_addr = wr_addr;
    next_rdata = 32'h0000_0000;
    next_start_bit = start_bit;
    next_irq_flag = irq_flag;
    next_channel_select = channel_select;
    next_input_class_select = input_class_select;
    next_converter_clock_divider = converter_clock_divider;
    next_reference_source_select = reference_source_select;
    next_amp_input_select = amp_input_select;
    next_pin_function_select = pin_function_select;
    next_pull_request = pull_request;
    start_pulse = 1'b0;
    if (wr_pend) begin
      case (wr_addr)
        ADDR_CTRL0: begin
          next_start_bit = HWDATA_IN[START_BIT];
          // Falling edge of the start bit after a rise launches the sequence
          start_pulse = start_bit && !HWDATA_IN[START_BIT];
          next_irq_flag = irq_flag && HWDATA_IN[IRQF_BIT]; // Zero clears, one keeps
        end
        ADDR_CTRL1: begin
          next_channel_select = HWDATA_IN[CHAN_LSB +: 4];
          next_input_class_select = HWDATA_IN[CLASS_LSB +: 4];
          next_converter_clock_divider = HWDATA_IN[DIV_LSB +: 3];
        end
        ADDR_CTRL2: begin
          next_reference_source_select = HWDATA_IN[REF_LSB +: 2];
          next_amp_input_select = HWDATA_IN[AMPIN_BIT];
        end
        ADDR_PINFS: begin
          next_pin_function_select = HWDATA_IN[NPINS-1:0];
          next_pull_request = HWDATA_IN[PULL_LSB +: NPINS];
        end
        default: ;
      endcase
    end
    // Completion sets the flag; set beats a same-cycle clear
    next_irq_flag = next_irq_flag || done_pulse;
    if (HSEL_IN && HREADY_IN && HTRANS_IN[1]) begin
      next_wr_pend = HWRITE_IN;
      next_wr_addr = HADDR_IN[7:0];
      if (!HWRITE_IN) begin
        case (HADDR_IN[7:0])
          ADDR_CTRL0: begin
            next_rdata[START_BIT] = start_bit;
            next_rdata[BUSY_BIT] = busy;
            next_rdata[IRQF_BIT] = irq_flag;
            next_rdata[PHASE_LSB +: 2] = state;
          end
          ADDR_CTRL1: begin
            next_rdata[CHAN_LSB +: 4] = channel_select;
            next_rdata[CLASS_LSB +: 4] = input_class_select;
            next_rdata[DIV_LSB +: 3] = converter_clock_divider;
          end
          ADDR_CTRL2: begin
            next_rdata[REF_LSB +: 2] = reference_source_select;
            next_rdata[AMPIN_BIT] = amp_input_select;
          end
          ADDR_PINFS: begin
            next_rdata[NPINS-1:0] = pin_function_select;
            next_rdata[PULL_LSB +: NPINS] = pull_request;
          end
          ADDR_ROUTE: begin
            next_rdata[RREF_LSB +: 2] = ref_route;
            next_rdata[RAMP_BIT] = amp_bg;
            next_rdata[RSRC_LSB +: 4] = src_route;
            next_rdata[RCH_LSB +: 4] = channel_select;
            next_rdata[RFLOAT_BIT] = (src_route == SRC_FLOAT);
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      HRDATA_OUT <= RESET_WORD;
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT <= 1'b0;
      start_bit <= 1'b0;
      irq_flag <= 1'b0;
      channel_select <= 4'h0;
      input_class_select <= 4'h0;
      converter_clock_divider <= 3'h0;
      reference_source_select <= 2'h0;
      amp_input_select <= 1'b0;
      pin_function_select <= '0;
      pull_request <= '0;
    end else begin
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      HRDATA_OUT <= next_rdata;
      HREADYOUT_OUT <= 1'b1; // Zero-wait slave, always OKAY
      HRESP_OUT <= 1'b0;
      start_bit <= next_start_bit;
      irq_flag <= next_irq_flag;
      channel_select <= next_channel_select;
      input_class_select <= next_input_class_select;
      converter_clock_divider <= next_converter_clock_divider;
      reference_source_select <= next_reference_source_select;
      amp_input_select <= next_amp_input_select;
      pin_function_select <= next_pin_function_select;
      pull_request <= next_pull_request;
    end
  end

  // ****************************************
  // Converter clock
  // ****************************************
  adcsel_clkdiv #(
    .DIV_W(3)
  ) u_clkdiv (
    .clk_in(CLK_IN),
    .rst_in(SYS_RST_IN),
    .restart_in(start_pulse),
    .div_sel_in(converter_clock_divider),
    .tick_out(tick)
  );

  // ****************************************
  // Input source decode
  // ****************************************
  // Internal classes take priority and switch the pins off
  always_comb begin
    live_chan = '0;
    case (input_class_select)
      4'h1: live_src = SRC_VDD1;
      4'h2: live_src = SRC_VDD2;
      4'h3: live_src = SRC_VDD4;
      4'h5: live_src = SRC_AMP1;
      4'h6: live_src = SRC_AMP2;
      4'h7: live_src = SRC_AMP4;
      4'h8, 4'h9, 4'hA, 4'hB: live_src = SRC_GND;
      default: begin // External classes 0000, 0100, 1100-1111
        if (channel_select < 4'(NPINS)) begin
          live_src = SRC_EXT;
          live_chan[channel_select] = 1'b1;
        end else begin
          live_src = SRC_FLOAT;
        end
      end
    endcase
  end

  // ****************************************
  // Conversion sequencer
  // ****************************************
  always_comb begin
    next_state = state;
    next_period_cnt = period_cnt;
    next_ref_route = ref_route;
    next_amp_bg = amp_bg;
    next_src_route = src_route;
    next_chan_en = chan_en;
    done_pulse = 1'b0;
    // Routing tracks software while idle, latched by a start, frozen until the end
    if (!busy || start_pulse) begin
      next_ref_route = reference_source_select[1] ? REF_AMP :
                       reference_source_select;
      next_amp_bg = amp_input_select;
      next_src_route = live_src;
      next_chan_en = live_chan;
    end
    if (start_pulse) begin
      // Restart from sampling whatever phase is running
      next_state = ADCSEL_SAMPLE;
      next_period_cnt = 4'h0;
    end else if (tick) begin
      case (state)
        ADCSEL_SAMPLE: begin
          if (period_cnt == SAMPLE_PERIODS - 4'h1) begin
            next_state = ADCSEL_CONVERT;
            next_period_cnt = 4'h0;
          end else begin
            next_period_cnt = period_cnt + 4'h1;
          end
        end
        ADCSEL_CONVERT: begin
          if (period_cnt == CONVERT_PERIODS - 4'h1) begin
            next_state = ADCSEL_IDLE;
            next_period_cnt = 4'h0;
            done_pulse = 1'b1;
          end else begin
            next_period_cnt = period_cnt + 4'h1;
          end
        end
        ADCSEL_IDLE: ;
        default: begin
          next_state = ADCSEL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      state <= ADCSEL_IDLE;
      period_cnt <= 4'h0;
      ref_route <= REF_SUPPLY;
      amp_bg <= 1'b0;
      src_route <= SRC_EXT;
      chan_en <= '0;
    end else begin
      state <= next_state;
      period_cnt <= next_period_cnt;
      ref_route <= next_ref_route;
      amp_bg <= next_amp_bg;
      src_route <= next_src_route;
      chan_en <= next_chan_en;
    end
  end

  // ****************************************
  // Output registers and pin overrides
  // ****************************************
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      REF_ROUTE_OUT <= REF_SUPPLY;
      AMP_BANDGAP_OUT <= 1'b0;
      SRC_ROUTE_OUT <= SRC_EXT;
      CHAN_ENABLE_OUT <= '0;
      PIN_ALT_EN_OUT <= '0;
      PIN_PULL_EN_OUT <= '0;
      PIN_OE_OUT <= '0;
      SAMPLE_OUT <= 1'b0;
      CONVERT_OUT <= 1'b0;
      BUSY_OUT <= 1'b0;
      IRQ_FLAG_OUT <= 1'b0;
    end else begin
      REF_ROUTE_OUT <= next_ref_route;
      AMP_BANDGAP_OUT <= next_amp_bg;
      SRC_ROUTE_OUT <= next_src_route;
      CHAN_ENABLE_OUT <= next_chan_en;
      // Converter function disables other use, pull-high and drive
      PIN_ALT_EN_OUT <= ~next_pin_function_select;
      PIN_PULL_EN_OUT <= next_pull_request & ~next_pin_function_select;
      PIN_OE_OUT <= PORT_OE_IN & ~next_pin_function_select;
      SAMPLE_OUT <= (next_state == ADCSEL_SAMPLE);
      CONVERT_OUT <= (next_state == ADCSEL_CONVERT);
      BUSY_OUT <= (next_state != ADCSEL_IDLE);
      IRQ_FLAG_OUT <= next_irq_flag;
    end
  end
endmodule

`default_nettype wire

// [rtl/adcsel_pkg.sv]
package adcsel_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] ADDR_CTRL1 = 8'h04;
  localparam logic [7:0] ADDR_CTRL2 = 8'h08;
  localparam logic [7:0] ADDR_PINFS = 8'h0C;
  localparam logic [7:0] ADDR_ROUTE = 8'h10;

  // ****************************************
  // Field positions
  // ****************************************
  // CTRL0
  localparam int START_BIT = 0;
  localparam int BUSY_BIT = 1;
  localparam int IRQF_BIT = 2;
  localparam int PHASE_LSB = 4;
  // CTRL1
  localparam int CHAN_LSB = 0;
  localparam int CLASS_LSB = 4;
  localparam int DIV_LSB = 8;
  // CTRL2
  localparam int REF_LSB = 2;
  localparam int AMPIN_BIT = 4;
  // PINFS: bits 11:0 converter function, bits 27:16 pull-high request
  localparam int PULL_LSB = 16;
  // ROUTE status
  localparam int RREF_LSB = 0;
  localparam int RAMP_BIT = 2;
  localparam int RSRC_LSB = 4;
  localparam int RCH_LSB = 8;
  localparam int RFLOAT_BIT = 12;

  // ****************************************
  // Reset values and timing counts
  // ****************************************
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [3:0] SAMPLE_PERIODS = 4'h4;
  localparam logic [3:0] CONVERT_PERIODS = 4'hC;
  localparam int NUM_PINS = 12;

  // Reference routes
  localparam logic [1:0] REF_SUPPLY = 2'h0;
  localparam logic [1:0] REF_PIN = 2'h1;
  localparam logic [1:0] REF_AMP = 2'h2;

  // Converter input source codes
  localparam logic [3:0] SRC_EXT = 4'h0;
  localparam logic [3:0] SRC_VDD1 = 4'h1;
  localparam logic [3:0] SRC_VDD2 = 4'h2;
  localparam logic [3:0] SRC_VDD4 = 4'h3;
  localparam logic [3:0] SRC_AMP1 = 4'h5;
  localparam logic [3:0] SRC_AMP2 = 4'h6;
  localparam logic [3:0] SRC_AMP4 = 4'h7;
  localparam logic [3:0] SRC_GND = 4'h8;
  localparam logic [3:0] SRC_FLOAT = 4'hF;

  typedef enum logic [1:0] {
    ADCSEL_IDLE,
    ADCSEL_SAMPLE,
    ADCSEL_CONVERT
  } adcsel_state_t;

endpackage

// [rtl/adcsel_clkdiv.sv]
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Converter clock tick generator
// ****************************************
module adcsel_clkdiv #(
  parameter int DIV_W = 3
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic restart_in,
  input wire logic [DIV_W-1:0] div_sel_in,
  output logic tick_out
);
  logic [7:0] count;
  logic [7:0] next_count;
  logic [7:0] limit;
  logic next_tick;

  // Tick once every 2**div_sel system clocks
  always_comb begin
    limit = 8'((9'h001 << div_sel_in) - 9'h001);
    next_tick = 1'b0;
    if (restart_in) begin
      next_count = 8'h00;
    end else if (count >= limit) begin
      next_count = 8'h00;
      next_tick = 1'b1;
    end else begin
      next_count = count + 8'h01;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count <= 8'h00;
      tick_out <= 1'b0;
    end else begin
      count <= next_count;
      tick_out <= next_tick;
    end
  end
endmodule

`default_nettype wire

// [sim/adcsel_sva.sv]
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Port checks for the converter selector
// ****************************************
module adcsel_sva #(
  parameter int NPINS = 12
) (
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic HREADYOUT_OUT,
  input wire logic HRESP_OUT,
  input wire logic [1:0] REF_ROUTE_OUT,
  input wire logic [3:0] SRC_ROUTE_OUT,
  input wire logic [NPINS-1:0] CHAN_ENABLE_OUT,
  input wire logic [NPINS-1:0] PIN_ALT_EN_OUT,
  input wire logic [NPINS-1:0] PIN_PULL_EN_OUT,
  input wire logic [NPINS-1:0] PIN_OE_OUT,
  input wire logic SAMPLE_OUT,
  input wire logic CONVERT_OUT,
  input wire logic BUSY_OUT,
  input wire logic IRQ_FLAG_OUT
);
  logic [10:0] conv_len, next_conv_len;

  // Counts system clocks spent in the conversion phase
  always_comb begin
    next_conv_len = CONVERT_OUT ? conv_len + 11'h001 : 11'h000;
  end

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      conv_len <= 11'h000;
    end else begin
      conv_len <= next_conv_len;
    end
  end

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);

  a_bus_okay: assert property (HREADYOUT_OUT && !HRESP_OUT)
    else $error("bus answer not ready or not okay");
  a_ref_legal: assert property (REF_ROUTE_OUT != 2'h3)
    else $error("reference route out of range");
  a_chan_onehot: assert property ($onehot0(CHAN_ENABLE_OUT))
    else $error("more than one channel switch closed");
  a_internal_wins: assert property (SRC_ROUTE_OUT != 4'h0 |-> CHAN_ENABLE_OUT == '0)
    else $error("pin switch closed on internal source");
  a_pull_off: assert property ((PIN_PULL_EN_OUT & ~PIN_ALT_EN_OUT) == '0)
    else $error("pull-high left on converter pin");
  a_oe_override: assert property ((PIN_OE_OUT & ~PIN_ALT_EN_OUT) == '0)
    else $error("converter pin still driven");
  a_busy_phases: assert property (BUSY_OUT == (SAMPLE_OUT || CONVERT_OUT))
    else $error("busy does not match the phases");
  a_sample_hold: assert property ($rose(SAMPLE_OUT) |-> SAMPLE_OUT [*4])
    else $error("sampling phase too short");
  // A restart may cut the conversion short, so only a natural end is measured
  a_convert_hold: assert property ($fell(CONVERT_OUT) && !SAMPLE_OUT |->
    conv_len >= 11'h00C)
    else $error("conversion phase too short");
  a_sample_then_conv: assert property ($fell(SAMPLE_OUT) |-> CONVERT_OUT)
    else $error("sampling not followed by conversion");
  a_irq_at_end: assert property ($fell(BUSY_OUT) |-> IRQ_FLAG_OUT)
    else $error("completion flag not raised at end");
  a_route_frozen: assert property (CONVERT_OUT && $past(CONVERT_OUT) |->
    $stable(SRC_ROUTE_OUT) && $stable(REF_ROUTE_OUT) && $stable(CHAN_ENABLE_OUT))
    else $error("routing changed during conversion");

  c_done: cover property ($fell(BUSY_OUT));
  c_ground: cover property (SRC_ROUTE_OUT == 4'h8);
  c_restart: cover property ($rose(SAMPLE_OUT) && $past(BUSY_OUT));
endmodule

bind adcsel_top adcsel_sva #(.NPINS(NPINS)) u_sva (.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN),
  .HREADYOUT_OUT(HREADYOUT_OUT), .HRESP_OUT(HRESP_OUT), .REF_ROUTE_OUT(REF_ROUTE_OUT),
  .SRC_ROUTE_OUT(SRC_ROUTE_OUT), .CHAN_ENABLE_OUT(CHAN_ENABLE_OUT),
  .PIN_ALT_EN_OUT(PIN_ALT_EN_OUT), .PIN_PULL_EN_OUT(PIN_PULL_EN_OUT),
  .PIN_OE_OUT(PIN_OE_OUT), .SAMPLE_OUT(SAMPLE_OUT), .CONVERT_OUT(CONVERT_OUT),
  .BUSY_OUT(BUSY_OUT), .IRQ_FLAG_OUT(IRQ_FLAG_OUT));

`default_nettype wire

// [sim/adcsel_top_test.sv]
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Self-checking bench for the selector
// ****************************************
module adcsel_top_test;
  import adcsel_pkg::*;
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [1:0] htrans = 2'h0;
  logic [11:0] port_oe = 12'h000;
  wire logic hready, hresp, amp_bg, smp, cnv, busy, irq;
  wire logic [31:0] hrdata;
  wire logic [1:0] ref_route;
  wire logic [3:0] src;
  wire logic [11:0] chan_en, alt_en, pull_en, pin_oe;
  int n_errors = 0, n_compared = 0;

  adcsel_top #(.NPINS(12)) uut (.CLK_IN(clk), .SYS_RST_IN(rst), .HSEL_IN(hsel),
    .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2),
    .HWDATA_IN(hwdata), .HREADY_IN(hready), .PORT_OE_IN(port_oe), .HRDATA_OUT(hrdata),
    .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .REF_ROUTE_OUT(ref_route),
    .AMP_BANDGAP_OUT(amp_bg), .SRC_ROUTE_OUT(src), .CHAN_ENABLE_OUT(chan_en),
    .PIN_ALT_EN_OUT(alt_en), .PIN_PULL_EN_OUT(pull_en), .PIN_OE_OUT(pin_oe),
    .SAMPLE_OUT(smp), .CONVERT_OUT(cnv), .BUSY_OUT(busy), .IRQ_FLAG_OUT(irq));

  // System clock, 4 ns period
  always #2 clk = ~clk;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %08h expected %08h", $time, got, exp);
    end
  endtask

  task automatic in_range(input int v, input int lo, input int hi);
    check({31'h0, v >= lo && v <= hi}, 32'h1);
  endtask

  // One single bus transfer: address phase, then data phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk); // Requests always start on a rising edge
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  // Lets registered outputs catch up after a write
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic start_pulse;
    wr(ADDR_CTRL0, 32'h1);
    wr(ADDR_CTRL0, 32'h0);
  endtask

  // Counts busy and sampling cycles over a fixed window
  task automatic count_phases(input int span, output int nb, output int ns);
    nb = 0;
    ns = 0;
    repeat (span) begin
      @(posedge clk);
      #1;
      nb += (busy === 1'b1);
      ns += (smp === 1'b1);
    end
  endtask

  task automatic stop_test;
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Watchdog against a hung handshake or sequencer
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    stop_test;
  end

  // Main test sequence
  initial begin
    logic ext;
    logic [3:0] es;
    logic [11:0] fs;
    int nb, ns, d;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdchk(ADDR_CTRL1, 32'h0);
    rdchk(ADDR_CTRL2, 32'h0);
    rdchk(8'h40, 32'h0);
    // All pins handed to the converter before a reference pin is chosen
    wr(ADDR_PINFS, 32'h0000_0FFF);
    settle;
    check({20'h0, alt_en}, 32'h0);
    for (int r = 0; r < 4; r++) begin
      for (int b = 0; b < 2; b++) begin
        wr(ADDR_CTRL2, (b << AMPIN_BIT) | (r << REF_LSB));
        settle;
        check({30'h0, ref_route}, (r >= 2) ? 32'h2 : r);
        check({31'h0, amp_bg}, b);
      end
    end
    for (int c = 0; c < 16; c++) begin
      for (int h = 0; h < 16; h++) begin
        wr(ADDR_CTRL1, (c << CLASS_LSB) | h);
        settle;
        ext = (c == 0 || c == 4 || c >= 12);
        es = ext ? ((h < 12) ? SRC_EXT : SRC_FLOAT) : ((c >= 8) ? SRC_GND : 4'(c));
        check({28'h0, src}, {28'h0, es});
        check({20'h0, chan_en}, (ext && h < 12) ? (32'h1 << h) : 32'h0);
      end
    end
    rdchk(ADDR_CTRL1, 32'hFF);
    // Amplifier reference, bandgap, floating class F on channel F
    rdchk(ADDR_ROUTE, 32'h0000_1FF6);
    port_oe <= 12'h3F0;
    for (int i = 0; i < 2; i++) begin
      fs = i ? 12'hA5C : 12'h000;
      wr(ADDR_PINFS, {4'h0, 12'hFFF, 4'h0, fs});
      settle;
      check({20'h0, alt_en}, {20'h0, ~fs});
      check({20'h0, pull_en}, {20'h0, ~fs});
      check({20'h0, pin_oe}, {20'h0, 12'h3F0 & ~fs});
    end
    for (int k = 0; k < 4; k++) begin
      d = (k == 3) ? 7 : k;
      wr(ADDR_CTRL1, (d << DIV_LSB) | (1 << CLASS_LSB));
      settle;
      start_pulse;
      count_phases((16 << d) + (1 << d) + 8, nb, ns);
      in_range(nb, 16 << d, (16 << d) + (1 << d));
      in_range(ns, 4 << d, (4 << d) + (1 << d));
      check({31'h0, irq}, 32'h1);
      rdchk(ADDR_CTRL0, 32'h4);
      wr(ADDR_CTRL0, 32'h0);
      settle;
      check({31'h0, irq}, 32'h0);
    end
    wr(ADDR_CTRL1, 32'h20);
    settle;
    start_pulse;
    wr(ADDR_CTRL1, 32'h30);
    #1;
    check({28'h0, src}, {28'h0, SRC_VDD2});
    check({31'h0, busy}, 32'h1);
    count_phases(30, nb, ns);
    check({28'h0, src}, {28'h0, SRC_VDD4});
    start_pulse;
    repeat (6) @(posedge clk);
    start_pulse;
    count_phases(30, nb, ns);
    in_range(nb, 16, 18);
    in_range(ns, 4, 6);
    stop_test;
  end
endmodule

`default_nettype wire
